//--- core/osa_params.svh
// constants for the optical switch and attenuator port controller
// Summary of operation
// (R1) released park: code n joins common 1 to channel n+1; code 31 blocks it
// (R2) non-blocking 2xN: common 2 follows code n; code 0 blocks common 2
// (R3) park low drives both commons to reset whatever the code bits hold
// (R4) after busy rises, travel takes 16 ms per channel passed
// (R5) host ignores optical output while the armature travels
// (R6) 300 ms debounce after travel, then busy drops
// (R7) prism switches follow relay register 00h writes directly, nothing else
// (R8) four ports each jumpered as switch port or attenuator port
// (R9) write to relay 02..05 on an attenuator port starts its command
// (R10) host writes a control word then the attenuator data word
// (R11) attenuator resets itself at power-up and parks at minimum loss
// (R12) uncalibrated step: one motor step up or down, no dB conversion
// (R13) calibrated set: dB request becomes a step position, motor goes there
// (R14) after an uncalibrated step the attenuation query is invalid until calibrated move
// (R15) busy rises on set or reset and stays while command runs
// (R16) host sends no command while busy is high
// (R17) error on out-of-range request or failed park search
// (R18) host reads min 82h and max 83h before calibrated use
// (R19) opcode 80h sets the attenuation
// (R20) channel code leaves on five parallel lines 4..0
// (R21) busy and error levels readable by software
// (R22) new port command held until busy is low
`ifndef OSA_PARAMS_SVH
`define OSA_PARAMS_SVH

`define OSA_CLK_KHZ 40000
`define OSA_TRAVEL_MS 16
`define OSA_DEBOUNCE_MS 300
`define OSA_STEP_US 2000
`define OSA_TRAVEL_CYC (`OSA_TRAVEL_MS * `OSA_CLK_KHZ)
`define OSA_DEBOUNCE_CYC (`OSA_DEBOUNCE_MS * `OSA_CLK_KHZ)
`define OSA_STEP_CYC (`OSA_STEP_US * `OSA_CLK_KHZ / 1000)

`define OSA_NPORT 4
`define OSA_CODE_W 5

`define OSA_IDX_PRISM 6'h00
`define OSA_IDX_RELAY_FIRST 6'h02
`define OSA_IDX_PARK 6'h09
`define OSA_IDX_STATUS 6'h0a
`define OSA_IDX_ATTOP 6'h0c
`define OSA_IDX_RESULT 6'h10

`define OSA_ST_BUSY_LSB 0
`define OSA_ST_ERR_LSB 8
`define OSA_ST_PEND_LSB 16
`define OSA_ST_JMP_LSB 24

`define OSA_PARK_RST 4'hf
`define OSA_ATTOP_RST 8'h80

`define OSA_OP_SET 8'h80
`define OSA_OP_QATT 8'h81
`define OSA_OP_QMIN 8'h82
`define OSA_OP_QMAX 8'h83
`define OSA_OP_UP 8'h84
`define OSA_OP_DOWN 8'h85
`define OSA_OP_RESET 8'h86

`endif

//--- core/osa_pkg.sv
// types shared by the optical port controller
package osa_pkg;
    typedef enum logic [1:0] {OSA_IDLE, OSA_TRAVEL, OSA_SETTLE} osa_state_e;
    typedef logic [7:0] osa_op_t;
endpackage

//--- core/osa_port.sv
// one port engine: armature or attenuator motor with travel and debounce
`timescale 1ns/1ps
`default_nettype none
`include "osa_params.svh"
module osa_port
    import osa_pkg::*;
#(
    parameter logic [23:0] TRAVEL_CYC = 24'(`OSA_TRAVEL_CYC),
    parameter logic [23:0] SETTLE_CYC = 24'(`OSA_DEBOUNCE_CYC),
    parameter logic [23:0] STEP_CYC = 24'(`OSA_STEP_CYC),
    parameter int STEP_W = 12,
    parameter logic [15:0] ATT_MIN = 16'h0000,
    parameter logic [15:0] ATT_MAX = 16'h04b0
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic is_atten,
    input wire logic park_n,
    input wire logic start,
    input wire osa_op_t op,
    input wire logic [15:0] data,
    input wire logic home_ok,
    output logic taken,
    output logic busy_q,
    output logic error_q,
    output logic [`OSA_CODE_W-1:0] code_q,
    output logic [15:0] result_q,
    output logic valid_q
);
    osa_state_e st_q, st_d;
    logic [23:0] cnt_q, cnt_d, unit;
    logic [STEP_W-1:0] pos_q, pos_d, tgt_q, tgt_d;
    logic busy_d, error_d, valid_d, boot_q, boot_d, homing_q, homing_d;
    logic [`OSA_CODE_W-1:0] code_d;
    logic [15:0] result_d;

    assign unit = is_atten ? STEP_CYC : TRAVEL_CYC;

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        pos_d = pos_q;
        tgt_d = tgt_q;
        error_d = error_q;
        valid_d = valid_q;
        boot_d = boot_q;
        homing_d = homing_q;
        code_d = code_q;
        result_d = result_q;
        taken = 1'b0;
        case (st_q)
            OSA_IDLE: begin
                if (boot_q || (!park_n && pos_q != '0)) begin
                    // power-up homing and park both end at position zero
                    st_d = OSA_TRAVEL; // R3 R11
                    tgt_d = '0;
                    boot_d = 1'b0;
                    homing_d = 1'b1;
                    error_d = 1'b0;
                    cnt_d = '0;
                end else if (start && park_n) begin
                    taken = 1'b1;
                    cnt_d = '0;
                    if (!is_atten) begin
                        code_d = data[`OSA_CODE_W-1:0]; // R20
                        // position k+1 is common 1 on k+1, common 2 on k
                        tgt_d = STEP_W'(data[`OSA_CODE_W-1:0]) + STEP_W'(1); // R1 R2
                        st_d = OSA_TRAVEL;
                    end else begin
                        case (op)
                            `OSA_OP_SET: begin // R19
                                if (data < ATT_MIN || data > ATT_MAX) begin
                                    error_d = 1'b1; // R17
                                end else begin
                                    tgt_d = data[STEP_W-1:0]; // R13
                                    valid_d = 1'b1; // R14
                                    error_d = 1'b0;
                                    st_d = OSA_TRAVEL; // R15
                                end
                            end
                            `OSA_OP_UP: begin
                                if (pos_q < ATT_MAX[STEP_W-1:0]) begin
                                    tgt_d = pos_q + STEP_W'(1); // R12
                                    valid_d = 1'b0; // R14
                                    st_d = OSA_TRAVEL;
                                end
                            end
                            `OSA_OP_DOWN: begin
                                if (pos_q != '0) begin
                                    tgt_d = pos_q - STEP_W'(1); // R12
                                    valid_d = 1'b0; // R14
                                    st_d = OSA_TRAVEL;
                                end
                            end
                            `OSA_OP_RESET: begin
                                tgt_d = '0;
                                homing_d = 1'b1;
                                error_d = 1'b0;
                                st_d = OSA_TRAVEL; // R15
                            end
                            `OSA_OP_QATT: result_d = 16'(pos_q);
                            `OSA_OP_QMIN: result_d = ATT_MIN;
                            `OSA_OP_QMAX: result_d = ATT_MAX;
                            default: result_d = result_q;
                        endcase
                    end
                end
            end
            OSA_TRAVEL: begin
                if (pos_q == tgt_q) begin
                    st_d = OSA_SETTLE;
                    cnt_d = '0;
                end else if (cnt_q == unit - 24'h00_0001) begin
                    cnt_d = '0;
                    pos_d = (tgt_q > pos_q) ? pos_q + STEP_W'(1) : pos_q - STEP_W'(1); // R4
                end else begin
                    cnt_d = cnt_q + 24'h00_0001;
                end
            end
            OSA_SETTLE: begin
                if (cnt_q == SETTLE_CYC - 24'h00_0001) begin
                    st_d = OSA_IDLE; // R6
                    cnt_d = '0;
                    homing_d = 1'b0;
                    if (homing_q && !home_ok) begin
                        error_d = 1'b1; // R17
                    end
                end else begin
                    cnt_d = cnt_q + 24'h00_0001;
                end
            end
            default: st_d = OSA_IDLE;
        endcase
        busy_d = (st_d != OSA_IDLE); // R15
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            st_q <= OSA_IDLE;
            cnt_q <= '0;
            pos_q <= '0;
            tgt_q <= '0;
            busy_q <= 1'b0;
            error_q <= 1'b0;
            valid_q <= 1'b0;
            boot_q <= 1'b1;
            homing_q <= 1'b0;
            code_q <= '0;
            result_q <= 16'h0000;
        end else if (ce) begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            pos_q <= pos_d;
            tgt_q <= tgt_d;
            busy_q <= busy_d;
            error_q <= error_d;
            valid_q <= valid_d;
            boot_q <= boot_d;
            homing_q <= homing_d;
            code_q <= code_d;
            result_q <= result_d;
        end
    end
endmodule
`default_nettype wire

//--- core/osa_ctrl.sv
// optical switch and attenuator controller with wishbone register file
`timescale 1ns/1ps
`default_nettype none
`include "osa_params.svh"
module osa_ctrl
    import osa_pkg::*;
#(
    parameter logic [23:0] TRAVEL_CYC = 24'(`OSA_TRAVEL_CYC),
    parameter logic [23:0] SETTLE_CYC = 24'(`OSA_DEBOUNCE_CYC),
    parameter logic [23:0] STEP_CYC = 24'(`OSA_STEP_CYC),
    parameter int STEP_W = 12,
    parameter logic [15:0] ATT_MIN = 16'h0000,
    parameter logic [15:0] ATT_MAX = 16'h04b0
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [`OSA_NPORT-1:0] port_atten_i,
    input wire logic [`OSA_NPORT-1:0] home_ok_i,
    output logic [7:0] prism_ctrl_o,
    output logic [`OSA_NPORT*`OSA_CODE_W-1:0] channel_code_o,
    output logic [`OSA_NPORT-1:0] park_n_o,
    output logic [`OSA_NPORT-1:0] busy_o,
    output logic [`OSA_NPORT-1:0] error_o
);
    localparam int NPORT = `OSA_NPORT;

    logic [5:0] idx;
    logic acc, wr_en;
    logic ack_q, ack_d;
    logic [31:0] dat_q, dat_d;
    logic [7:0] relay0_q, relay0_d;
    logic [3:0] park_q, park_d;
    logic [3:0] jmp_q;
    logic [31:0] rd;
    logic [31:0] mrg_relay0, mrg_park;

    logic [NPORT-1:0] busy_w, err_w, valid_w, pend_w;
    logic [15:0] res_w [NPORT];
    logic [15:0] pdat_w [NPORT];
    osa_op_t aop_w [NPORT];

    // byte-lane merge of a write into a stored word
    function automatic logic [31:0] osa_merge(
        input logic [31:0] old,
        input logic [31:0] nw,
        input logic [3:0] sel
    );
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return r;
    endfunction

    assign idx = wb_adr_i[7:2];
    assign acc = wb_cyc_i & wb_stb_i & ~ack_q;
    assign wr_en = acc & wb_we_i;
    assign mrg_relay0 = osa_merge({24'h00_0000, relay0_q}, wb_dat_i, wb_sel_i);
    assign mrg_park = osa_merge({28'h000_0000, park_q}, wb_dat_i, wb_sel_i);

    // read mux; unmapped words read zero
    always_comb begin
        rd = 32'h0000_0000;
        if (idx == `OSA_IDX_PRISM) begin
            rd = {24'h00_0000, relay0_q};
        end else if (idx == `OSA_IDX_PARK) begin
            rd = {28'h000_0000, park_q};
        end else if (idx == `OSA_IDX_STATUS) begin
            rd[`OSA_ST_BUSY_LSB +: 4] = busy_w; // R21
            rd[`OSA_ST_ERR_LSB +: 4] = err_w; // R21
            rd[`OSA_ST_PEND_LSB +: 4] = pend_w;
            rd[`OSA_ST_JMP_LSB +: 4] = jmp_q;
        end
        for (int p = 0; p < NPORT; p++) begin
            if (idx == 6'(`OSA_IDX_RELAY_FIRST + p)) begin
                rd = {16'h0000, pdat_w[p]};
            end
            if (idx == 6'(`OSA_IDX_ATTOP + p)) begin
                rd = {24'h00_0000, aop_w[p]};
            end
            if (idx == 6'(`OSA_IDX_RESULT + p)) begin
                rd = {15'h0000, valid_w[p], res_w[p]}; // R14
            end
        end
    end

    always_comb begin
        ack_d = acc;
        dat_d = acc ? rd : dat_q;
        relay0_d = relay0_q;
        park_d = park_q;
        if (wr_en && idx == `OSA_IDX_PRISM) begin
            relay0_d = mrg_relay0[7:0]; // R7
        end
        if (wr_en && idx == `OSA_IDX_PARK) begin
            park_d = mrg_park[3:0]; // R3
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
            relay0_q <= 8'h00;
            park_q <= `OSA_PARK_RST;
            jmp_q <= 4'h0;
        end else if (ce) begin
            ack_q <= ack_d;
            dat_q <= dat_d;
            relay0_q <= relay0_d;
            park_q <= park_d;
            jmp_q <= port_atten_i; // R8
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;
    assign prism_ctrl_o = relay0_q; // R7
    assign park_n_o = park_q;
    assign busy_o = busy_w;
    assign error_o = err_w;

    for (genvar p = 0; p < NPORT; p++) begin : g_port
        logic pend_q, pend_d, taken;
        logic [15:0] pdat_q, pdat_d;
        osa_op_t aop_q, aop_d, pop_q, pop_d;
        logic [`OSA_CODE_W-1:0] code;
        logic [31:0] mrg_pdat, mrg_aop;

        assign mrg_pdat = osa_merge({16'h0000, pdat_q}, wb_dat_i, wb_sel_i);
        assign mrg_aop = osa_merge({24'h00_0000, aop_q}, wb_dat_i, wb_sel_i);

        always_comb begin
            // a new write in the cycle of the hand-off re-arms the request
            pend_d = pend_q & ~taken; // R22
            pdat_d = pdat_q;
            aop_d = aop_q;
            pop_d = pop_q;
            if (wr_en && idx == 6'(`OSA_IDX_RELAY_FIRST + p)) begin
                pend_d = 1'b1; // R9
                pdat_d = mrg_pdat[15:0];
                pop_d = aop_q;
            end
            if (wr_en && idx == 6'(`OSA_IDX_ATTOP + p)) begin
                aop_d = mrg_aop[7:0]; // R10
            end
        end

        always_ff @(posedge mclk) begin
            if (!rst_n) begin
                pend_q <= 1'b0;
                pdat_q <= 16'h0000;
                aop_q <= `OSA_ATTOP_RST;
                pop_q <= `OSA_ATTOP_RST;
            end else if (ce) begin
                pend_q <= pend_d;
                pdat_q <= pdat_d;
                aop_q <= aop_d;
                pop_q <= pop_d;
            end
        end

        osa_port #(
            .TRAVEL_CYC(TRAVEL_CYC),
            .SETTLE_CYC(SETTLE_CYC),
            .STEP_CYC(STEP_CYC),
            .STEP_W(STEP_W),
            .ATT_MIN(ATT_MIN),
            .ATT_MAX(ATT_MAX)
        ) u_port (
            .mclk(mclk),
            .rst_n(rst_n),
            .ce(ce),
            .is_atten(jmp_q[p]),
            .park_n(park_q[p]),
            .start(pend_q),
            .op(pop_q),
            .data(pdat_q),
            .home_ok(home_ok_i[p]),
            .taken(taken),
            .busy_q(busy_w[p]),
            .error_q(err_w[p]),
            .code_q(code),
            .result_q(res_w[p]),
            .valid_q(valid_w[p])
        );

        assign channel_code_o[p*`OSA_CODE_W +: `OSA_CODE_W] = code; // R20
        assign pend_w[p] = pend_q;
        assign pdat_w[p] = pdat_q;
        assign aop_w[p] = aop_q;
    end
endmodule
`default_nettype wire

//--- test/osa_ctrl_monitor.sv
// bound assertions for the optical port controller
`timescale 1ns/1ps
`default_nettype none
module osa_ctrl_chk (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic [7:0] prism_ctrl_o,
    input wire logic [19:0] channel_code_o,
    input wire logic [3:0] park_n_o,
    input wire logic [3:0] busy_o,
    input wire logic [3:0] error_o
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    logic req;
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && ce;
    chk_status_levels: assert property (req && !wb_we_i && wb_adr_i[7:2] == 6'h0a
        |=> wb_ack_o && wb_dat_o[3:0] == $past(busy_o) && wb_dat_o[11:8] == $past(error_o))
        else $error("status read does not show busy and error");
    chk_unmapped_zero: assert property (req && !wb_we_i && wb_adr_i[7:2] == 6'h01
        |=> wb_ack_o && wb_dat_o == 32'h0) else $error("unmapped relay read not zero");
    chk_prism_write: assert property (req && wb_we_i && wb_adr_i[7:2] == 6'h00 && wb_sel_i[0]
        |=> prism_ctrl_o == $past(wb_dat_i[7:0])) else $error("prism byte not applied");
    chk_prism_only: assert property (!(req && wb_we_i && wb_adr_i[7:2] == 6'h00)
        |=> $stable(prism_ctrl_o)) else $error("prism lines moved without a write");
    chk_settle_min: assert property ($rose(busy_o[0]) |-> busy_o[0] [*6])
        else $error("busy shorter than debounce");
    chk_busy_bounded: assert property ($rose(busy_o[0]) |-> ##[1:200] !busy_o[0])
        else $error("busy never dropped");
    chk_code_held: assert property (busy_o[0] && $past(busy_o[0])
        |-> $stable(channel_code_o[4:0])) else $error("code changed while busy");
    chk_park_holds: assert property (!park_n_o[0] && $past(!park_n_o[0])
        |-> $stable(channel_code_o[4:0])) else $error("code changed while parked");
endmodule
bind osa_ctrl osa_ctrl_chk u_chk (.mclk(mclk), .rst_n(rst_n), .ce(ce), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .prism_ctrl_o(prism_ctrl_o), .channel_code_o(channel_code_o), .park_n_o(park_n_o),
    .busy_o(busy_o), .error_o(error_o));
`default_nettype wire

//--- test/osa_far_model.sv
// far-side optical modules: park sensors and light validity
`timescale 1ns/1ps
`default_nettype none
module osa_far_model (
    input wire logic [3:0] busy_o,
    input wire logic [3:0] fail_home,
    output logic [3:0] home_ok_i,
    output logic [3:0] light_ok
);
    // sensor finds park unless a failure is commanded
    assign home_ok_i = ~fail_home;
    // output unusable while the armature travels
    assign light_ok = ~busy_o;
endmodule
`default_nettype wire

//--- test/tb_optical_switch_attenuator_control.sv
// testbench for the optical switch and attenuator controller
`timescale 1ns/1ps
`default_nettype none
module tb_optical_switch_attenuator_control;
    logic mclk = 0, rst_n = 0, ce = 1, cyc = 0, stb = 0, we = 0, ack;
    logic [7:0] adr = 0, prism;
    logic [3:0] sel = 4'hf, park_n, busy, err, home_ok, lok, fail_home = 4'h8;
    logic [31:0] dat = 0, dat_o, d, exp_q[$], msk_q[$];
    logic [19:0] code;
    int n_fail = 0, checks = 0, cnt, e, pos = 0, codes[4] = '{5, 31, 0, 9};
    logic [7:0] aop[4] = '{8'h80, 8'h84, 8'h85, 8'h80};
    logic [15:0] adt[4] = '{16'h0014, 16'h0000, 16'h0000, 16'h000a};
    logic [31:0] aex[4] = '{32'h0001_0014, 32'h0000_0015, 32'h0000_0014, 32'h0001_000a};
    osa_ctrl #(.TRAVEL_CYC(24'h00_0004), .SETTLE_CYC(24'h00_0006), .STEP_CYC(24'h00_0003))
    u_dut (.mclk(mclk), .rst_n(rst_n), .ce(ce), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .port_atten_i(4'hc), .home_ok_i(home_ok), .prism_ctrl_o(prism),
        .channel_code_o(code), .park_n_o(park_n), .busy_o(busy), .error_o(err));
    osa_far_model u_far (.busy_o(busy), .fail_home(fail_home), .home_ok_i(home_ok),
        .light_ok(lok));
    initial begin
        forever #12.5 mclk = ~mclk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] ex);
        checks++;
        if (seen !== ex) begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, ex);
        end
    endtask
    task automatic give_verdict();
        $display("checks=%0d mismatches=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic tmo();
        n_fail++;
        give_verdict();
    endtask
    // read expectations are queued, the watcher compares them
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v,
            input logic [31:0] m);
        int i;
        if (!w) begin
            exp_q.push_back(v);
            msk_q.push_back(m);
        end
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= a;
        dat <= w ? v : 32'h0;
        for (i = 0; i < 50 && ack !== 1'b1; i++) @(posedge mclk);
        if (i >= 50) tmo();
        cyc <= 0;
        stb <= 0;
        @(posedge mclk);
    endtask
    task automatic run(input int p, output int c);
        c = 0;
        while (busy[p] !== 1'b0 && c < 400) begin
            @(posedge mclk);
            c++;
        end
        if (c >= 400) tmo();
    endtask
    task automatic acmd(input logic [7:0] op, input logic [15:0] v);
        wb(1, 8'h38, 32'(op), 32'h0);
        wb(1, 8'h10, 32'(v), 32'h0);
    endtask
    always @(posedge mclk) begin
        if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0) begin
            chk(dat_o & msk_q.pop_front(), exp_q.pop_front());
        end
    end
    initial begin
        void'($urandom(32'h7844_9350));
        repeat (5) @(posedge mclk);
        chk(32'({busy, err, park_n, prism}), 32'h0000_0f00);
        chk(32'(code), 32'h0);
        rst_n <= 1;
        // busy from the first edge after release is only seen one edge later
        repeat (2) @(posedge mclk);
        run(0, cnt);
        chk(32'(cnt >= 5 && cnt <= 9), 32'h1);
        run(3, cnt);
        chk(32'(err), 32'h8);
        wb(0, 8'h28, 32'h0c00_0800, 32'hffff_ffff);
        $display("test homing done");
        d = $urandom;
        wb(1, 8'h00, d, 32'h0);
        chk(32'(prism), 32'(d[7:0]));
        sel <= 4'he;
        wb(1, 8'h00, ~d, 32'h0);
        sel <= 4'hf;
        chk(32'(prism), 32'(d[7:0]));
        wb(0, 8'h00, 32'(d[7:0]), 32'h0000_00ff);
        wb(1, 8'h04, d, 32'h0);
        wb(0, 8'h04, 32'h0, 32'hffff_ffff);
        $display("test prism done");
        codes[3] = $urandom_range(30, 1);
        foreach (codes[i]) begin
            wb(1, 8'h08, 32'(codes[i]), 32'h0);
            // bit 5 is the far side's light flag, low while travelling
            chk(32'({lok[0], code[4:0]}), 32'(codes[i]));
            // frozen clock enable must not eat travel time
            ce <= 1'b0;
            repeat (3) @(posedge mclk);
            ce <= 1'b1;
            run(0, cnt);
            e = codes[i] + 1 - pos;
            e = 4 * (e < 0 ? -e : e) + 7;
            chk(32'(cnt >= e - 2 && cnt <= e + 2), 32'h1);
            pos = codes[i] + 1;
        end
        wb(1, 8'h08, 32'h9, 32'h0);
        wb(1, 8'h08, 32'h3, 32'h0);
        chk(32'(code[4:0]), 32'h9);
        run(0, cnt);
        @(posedge mclk);
        chk(32'({busy[0], code[4:0]}), 32'h23);
        run(0, cnt);
        $display("test switch done");
        wb(1, 8'h24, 32'he, 32'h0);
        chk(32'({park_n, 3'h0, busy[0]}), 32'he1);
        wb(1, 8'h08, 32'h7, 32'h0);
        run(0, cnt);
        chk(32'(code[4:0]), 32'h3);
        wb(1, 8'h24, 32'hf, 32'h0);
        @(posedge mclk);
        chk(32'(code[4:0]), 32'h7);
        run(0, cnt);
        $display("test park done");
        wb(0, 8'h38, 32'h80, 32'h0000_00ff);
        for (int i = 0; i < 2; i++) begin
            acmd(8'h82 + 8'(i), 16'h0);
            repeat (3) @(posedge mclk);
            wb(0, 8'h48, i == 0 ? 32'h0 : 32'h04b0, 32'h0000_ffff);
        end
        foreach (aop[i]) begin
            acmd(aop[i], adt[i]);
            run(2, cnt);
            acmd(8'h81, 16'h0);
            repeat (3) @(posedge mclk);
            wb(0, 8'h48, aex[i], 32'h0001_ffff);
        end
        acmd(8'h80, 16'h04b1);
        @(posedge mclk);
        chk(32'({busy[2], err[2]}), 32'h1);
        acmd(8'h86, 16'h0);
        chk(32'(busy[2]), 32'h1);
        run(2, cnt);
        chk(32'(err[2]), 32'h0);
        $display("test attenuator done");
        give_verdict();
    end
endmodule
`default_nettype wire
